// [rtl/scrx_pkg.sv]
// package: register map, field positions, reset values and link timing of the card receiver
package scrx_pkg;

   // ==========================================================
   // register bus
   localparam int          ADDR_W        = 2;
   localparam int          DATA_W        = 8;
   localparam logic [1:0]  ADDR_CTRL     = 2'h0;
   localparam logic [1:0]  ADDR_STAT     = 2'h1;
   localparam logic [1:0]  ADDR_RXDATA   = 2'h2;
   localparam logic [1:0]  ADDR_PORT     = 2'h3;

   // ==========================================================
   // serial_control_reg fields
   localparam int          CTL_CLOCK_ENABLE_LOW_BIT      = 0;
   localparam int          CTL_CLOCK_ENABLE_HIGH_BIT      = 1;
   localparam int          CTL_RE        = 4;
   localparam int          CTL_TE        = 5;
   localparam int          CTL_REIE      = 6;
   localparam int          CTL_RIE       = 7;
   localparam logic [7:0]  CTL_RESET     = 8'h00;

   // ==========================================================
   // serial_status_reg fields
   localparam int          STA_PER       = 3;
   localparam int          STA_FER       = 4;
   localparam int          STA_ORER      = 5;
   localparam int          STA_RECEIVE_FULL_FLAG      = 6;
   localparam logic [7:0]  STA_RESET     = 8'h00;

   // ==========================================================
   // port_data_reg fields: serial clock pin level and direction, and the transfer select
   localparam int          PRT_DATA      = 0;
   localparam int          PRT_DIR       = 1;
   localparam int          PRT_XFERSEL   = 7;
   localparam logic [7:0]  PRT_RESET     = 8'h00;

   // ==========================================================
   // link timing, in link clock cycles; FRAME_LAST is the index of the last bit
   localparam logic [3:0]  BIT_CYCLES    = 4'hf;
   localparam logic [3:0]  HALF_BIT      = 4'h7;
   localparam logic [3:0]  FRAME_LAST    = 4'h9;
   localparam logic [2:0]  SCK_LAST      = 3'h7;
   localparam logic [2:0]  SCK_HALF      = 3'h4;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_BITS
   } scrx_rxst_t;

   // link side state
   typedef struct packed {
      scrx_rxst_t  st;
      logic [3:0]  osCnt;
      logic [3:0]  bitCnt;
      logic [9:0]  shift;
      logic [7:0]  holdData;
      logic        holdPer;
      logic        holdFer;
      logic        reqTgl;
      logic [2:0]  sckCnt;
      logic        sckRun;
      logic        sckOut;
      logic        sckOe;
   } scrx_link_t;

   // system side state
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  stat;
      logic [7:0]  seen;
      logic [7:0]  rxData;
      logic [7:0]  port;
      logic        tglPrev;
      logic [7:0]  rdata;
   } scrx_sys_t;

endpackage

// [rtl/scrx_sync.sv]
// two-stage synchroniser for a group of levels
`timescale 1ns/10ps
`default_nettype none

module scrx_sync #(
   parameter int W = 1
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic [W-1:0]  din,
   output logic      [W-1:0]  dout
);

   logic [W-1:0] meta_q;

   // ==========================================================
   // first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

`default_nettype wire

// [rtl/scrx_top.sv]
// serial receive block with card clock stop/restart control
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module scrx_top
   import scrx_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               arst_n,
   input  wire logic               clkLink,
   input  wire logic               rxdPin,
   input  wire logic [ADDR_W-1:0]  addr,
   input  wire logic [DATA_W-1:0]  wdata,
   input  wire logic               wrEn,
   input  wire logic               rdEn,
   input  wire logic               lowPower,
   input  wire logic               xferDone,
   output logic      [DATA_W-1:0]  rdata,
   output logic                    rxFullIrq,
   output logic                    rxErrIrq,
   output logic                    xferReq,
   output logic                    sckOut,
   output logic                    sckOe
);

   // ==========================================================
   // declarations
   scrx_sys_t   sys_q;
   scrx_sys_t   sys_d;
   scrx_link_t  lnk_q;
   scrx_link_t  lnk_d;

   logic [5:0]  linkIn;
   logic [5:0]  linkSync;
   logic        rxdS;
   logic        lowPowerS;
   logic        rxEnS;
   logic        cke0S;
   logic        portDataS;
   logic        portDirS;
   logic        reqTglS;
   logic        newWord;
   logic [9:0]  nextShift;
   logic        errAny;

   // ==========================================================
   // crossings
   // levels from the system side and the data pin into the link domain
   assign linkIn = {rxdPin,
                    lowPower,
                    sys_q.ctrl[CTL_RE],
                    sys_q.ctrl[CTL_CLOCK_ENABLE_LOW_BIT],
                    sys_q.port[PRT_DATA],
                    sys_q.port[PRT_DIR]};

   scrx_sync #(
      .W      (6)
   ) u_linkSync (
      .clk    (clkLink),
      .arst_n (arst_n),
      .din    (linkIn),
      .dout   (linkSync)
   );

   assign rxdS      = linkSync[5];
   assign lowPowerS = linkSync[4];
   assign rxEnS     = linkSync[3];
   assign cke0S     = linkSync[2];
   assign portDataS = linkSync[1];
   assign portDirS  = linkSync[0];

   // a finished word is announced by a toggle; the held word stays put for a
   // whole frame, far longer than the few system cycles the crossing takes
   scrx_sync #(
      .W      (1)
   ) u_reqSync (
      .clk    (clk_sys),
      .arst_n (arst_n),
      .din    (lnk_q.reqTgl),
      .dout   (reqTglS)
   );

   assign newWord = reqTglS ^ sys_q.tglPrev;

   // ==========================================================
   // link domain: receiver and serial clock generator
   always_comb begin
      lnk_d     = lnk_q;
      nextShift = {rxdS, lnk_q.shift[9:1]};

      // receiver
      if (lowPowerS || !rxEnS) begin
         // a word in flight is thrown away, never delivered
         lnk_d.st     = RX_IDLE;
         lnk_d.shift  = '0;
         lnk_d.osCnt  = '0;
         lnk_d.bitCnt = '0;
      end else begin
         case (lnk_q.st)
            RX_IDLE: begin
               if (!rxdS) begin
                  lnk_d.st    = RX_START;
                  lnk_d.osCnt = '0;
               end
            end
            RX_START: begin
               lnk_d.osCnt = lnk_q.osCnt + 4'h1;
               if (lnk_q.osCnt == HALF_BIT) begin
                  // a start bit that vanishes before mid-bit is noise
                  if (rxdS) begin
                     lnk_d.st = RX_IDLE;
                  end else begin
                     lnk_d.st     = RX_BITS;
                     lnk_d.osCnt  = '0;
                     lnk_d.bitCnt = '0;
                  end
               end
            end
            RX_BITS: begin
               lnk_d.osCnt = lnk_q.osCnt + 4'h1;
               if (lnk_q.osCnt == BIT_CYCLES) begin
                  lnk_d.osCnt  = '0;
                  lnk_d.shift  = nextShift;
                  lnk_d.bitCnt = lnk_q.bitCnt + 4'h1;
                  if (lnk_q.bitCnt == FRAME_LAST) begin
                     // eight data bits, even parity, one stop bit
                     lnk_d.holdData = nextShift[7:0];
                     lnk_d.holdPer  = ^nextShift[8:0];
                     lnk_d.holdFer  = ~nextShift[9];
                     lnk_d.reqTgl   = ~lnk_q.reqTgl;
                     lnk_d.st       = RX_IDLE;
                  end
               end
            end
            default: begin
               lnk_d.st = RX_IDLE;
            end
         endcase
      end

      // serial clock: low half then high half of each period
      if (lnk_q.sckRun) begin
         lnk_d.sckCnt = lnk_q.sckCnt + 3'h1;
         if (lnk_q.sckCnt == SCK_LAST) begin
            // the stop waits for the end of the running period
            lnk_d.sckCnt = '0;
            lnk_d.sckRun = cke0S;
         end
      end else begin
         lnk_d.sckCnt = '0;
         // restart begins a fresh full low half
         lnk_d.sckRun = cke0S;
      end

      // stopped clock holds the programmed pin level
      lnk_d.sckOut = lnk_d.sckRun ? (lnk_d.sckCnt >= SCK_HALF) : portDataS;
      lnk_d.sckOe  = lnk_d.sckRun | portDirS;
   end

   always_ff @(posedge clkLink or negedge arst_n) begin
      if (!arst_n) begin
         lnk_q <= '{st: RX_IDLE, default: '0};
      end else begin
         lnk_q <= lnk_d;
      end
   end

   // ==========================================================
   // system domain: registers and flags
   always_comb begin
      sys_d       = sys_q;
      sys_d.rdata = 8'h00;
      errAny      = lnk_q.holdPer | lnk_q.holdFer;

      if (newWord) begin
         sys_d.tglPrev = reqTglS;
      end

      // reads; status reads arm the flag clear
      if (rdEn) begin
         case (addr)
            ADDR_CTRL: begin
               sys_d.rdata = sys_q.ctrl;
            end
            ADDR_STAT: begin
               sys_d.rdata = sys_q.stat;
               sys_d.seen  = sys_q.seen | sys_q.stat;
            end
            ADDR_RXDATA: begin
               sys_d.rdata = sys_q.rxData;
            end
            ADDR_PORT: begin
               sys_d.rdata = sys_q.port;
            end
            default: begin
               sys_d.rdata = 8'h00;
            end
         endcase
      end

      // writes
      if (wrEn) begin
         case (addr)
            ADDR_CTRL: begin
               sys_d.ctrl = wdata;
            end
            ADDR_STAT: begin
               // a zero clears only a flag seen as one; a one leaves it alone
               for (int i = STA_PER; i <= STA_RECEIVE_FULL_FLAG; i++) begin
                  if (!wdata[i] && sys_q.seen[i]) begin
                     sys_d.stat[i] = 1'b0;
                     sys_d.seen[i] = 1'b0;
                  end
               end
            end
            ADDR_PORT: begin
               sys_d.port = wdata;
            end
            default: begin
               sys_d.ctrl = sys_q.ctrl;
            end
         endcase
      end

      // transfer controller done with the word
      if (xferDone && sys_q.stat[STA_RECEIVE_FULL_FLAG]) begin
         sys_d.stat[STA_RECEIVE_FULL_FLAG] = 1'b0;
         sys_d.seen[STA_RECEIVE_FULL_FLAG] = 1'b0;
      end

      // arrivals come after the clears so a set beats a clear in the same cycle
      if (newWord && sys_q.ctrl[CTL_RE] && !lowPower) begin
         if (errAny) begin
            sys_d.stat[STA_PER] = sys_d.stat[STA_PER] | lnk_q.holdPer;
            sys_d.stat[STA_FER] = sys_d.stat[STA_FER] | lnk_q.holdFer;
         end else if (sys_d.stat[STA_RECEIVE_FULL_FLAG]) begin
            sys_d.stat[STA_ORER] = 1'b1;
         end else if (sys_d.stat[STA_ORER] | sys_d.stat[STA_FER] | sys_d.stat[STA_PER]) begin
            // reception is held off until software clears the error
            sys_d.stat = sys_d.stat;
         end else begin
            sys_d.rxData         = lnk_q.holdData;
            sys_d.stat[STA_RECEIVE_FULL_FLAG] = 1'b1;
         end
      end

      // entering a stop or standby mode wipes data and status
      if (lowPower) begin
         sys_d.rxData = 8'h00;
         sys_d.stat   = STA_RESET;
         sys_d.seen   = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sys_q <= '{ctrl: CTL_RESET, stat: STA_RESET, port: PRT_RESET, default: '0};
      end else begin
         sys_q <= sys_d;
      end
   end

   // ==========================================================
   // outputs
   assign rdata     = sys_q.rdata;
   // the full flag goes either to the cpu or to the transfer controller
   assign rxFullIrq = sys_q.stat[STA_RECEIVE_FULL_FLAG] & sys_q.ctrl[CTL_RIE]
                      & ~sys_q.port[PRT_XFERSEL];
   assign xferReq   = sys_q.stat[STA_RECEIVE_FULL_FLAG] & sys_q.ctrl[CTL_RIE]
                      & sys_q.port[PRT_XFERSEL];
   assign rxErrIrq  = (sys_q.stat[STA_ORER] | sys_q.stat[STA_FER] | sys_q.stat[STA_PER])
                      & sys_q.ctrl[CTL_REIE];
   assign sckOut    = lnk_q.sckOut;
   assign sckOe     = lnk_q.sckOe;

endmodule

`default_nettype wire

// [testbench/scrx_chk_sva.sv]
// checker: port-level assertions for the card receiver
`timescale 1ns/10ps
`default_nettype none

module scrx_chk
   import scrx_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              arst_n,
   input wire logic              clkLink,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wrEn,
   input wire logic              lowPower,
   input wire logic              xferDone,
   input wire logic              rxFullIrq,
   input wire logic              rxErrIrq,
   input wire logic              xferReq,
   input wire logic              sckOut
);
   // ==========================
   // sequences
   sequence sLowPhase;
      !sckOut [*4];
   endsequence
   sequence sHighPhase;
      sckOut [*4];
   endsequence
   // low power held for six system cycles before the flags must be clear
   sequence sLowHeld;
      lowPower [*6];
   endsequence

   // ==========================
   // serial clock
   AST_SCK_LOW: assert property (@(posedge clkLink) disable iff (!arst_n)
      $fell(sckOut) |-> sLowPhase) else $error("serial clock low phase short");
   AST_SCK_HIGH: assert property (@(posedge clkLink) disable iff (!arst_n)
      $rose(sckOut) |-> sHighPhase) else $error("serial clock high phase short");

   // ==========================
   // receive flags
   AST_IRQ_EXCL: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !(rxFullIrq && xferReq)) else $error("full irq and transfer request together");
   AST_XFER_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      xferReq && xferDone && !wrEn |=> !xferReq) else $error("transfer did not clear");
   AST_LP_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      sLowHeld |=> !rxFullIrq && !xferReq && !rxErrIrq) else $error("low power kept flags");
   AST_ERR_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rxErrIrq && !lowPower && !wrEn |=> rxErrIrq) else $error("error flag dropped");
   AST_ERR_ONES: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rxErrIrq && !lowPower && wrEn && addr == ADDR_STAT && wdata == 8'hff |=> rxErrIrq)
      else $error("writing ones cleared error");
   AST_FULL_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rxFullIrq && !lowPower && !wrEn && !xferDone |=> rxFullIrq)
      else $error("full irq dropped");
endmodule

bind scrx_top scrx_chk scrx_chk_inst (
   .clk_sys   (clk_sys),
   .arst_n    (arst_n),
   .clkLink   (clkLink),
   .addr      (addr),
   .wdata     (wdata),
   .wrEn      (wrEn),
   .lowPower  (lowPower),
   .xferDone  (xferDone),
   .rxFullIrq (rxFullIrq),
   .rxErrIrq  (rxErrIrq),
   .xferReq   (xferReq),
   .sckOut    (sckOut)
);

`default_nettype wire

// [testbench/scrx_peer.sv]
// serial peer: drives framed words onto the receive pin
`timescale 1ns/10ps
`default_nettype none

module scrx_peer (
   input  wire logic clkLink,
   output var  logic rxd
);
   initial rxd = 1'b1;
   // ==========================
   // start, 8 bits lsb first, even parity, stop; 16 link cycles a bit
   task automatic send(input logic [7:0] d, input logic badPar, input logic badStop);
      logic [10:0] f;
      f = {~badStop, (^d) ^ badPar, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clkLink);
         rxd <= f[i];
         repeat (15) @(posedge clkLink);
      end
      @(posedge clkLink);
      rxd <= 1'b1;
   endtask
endmodule

`default_nettype wire

// [testbench/scrx_top_bench.sv]
// bench: register-level tests of the card receiver
`timescale 1ns/10ps
`default_nettype none

module scrx_top_bench
   import scrx_pkg::*;
;
   logic              clk_sys, arst_n, clkLink, rxdPin, wrEn, rdEn, lowPower, xferDone;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic              rxFullIrq, rxErrIrq, xferReq, sckOut, sckOe;
   logic [7:0]        e;
   int                n_fail = 0, compares = 0, cyc = 0, n;

   scrx_top scrx_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .clkLink(clkLink),
      .rxdPin(rxdPin), .addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn),
      .lowPower(lowPower), .xferDone(xferDone), .rdata(rdata), .rxFullIrq(rxFullIrq),
      .rxErrIrq(rxErrIrq), .xferReq(xferReq), .sckOut(sckOut), .sckOe(sckOe));
   scrx_peer scrx_peer_inst (.clkLink(clkLink), .rxd(rxdPin));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // link clock phase offset on purpose
   initial begin
      clkLink = 1'b0;
      #13;
      forever #32 clkLink = ~clkLink;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         report_and_stop;
      end
   end

   // ==========================
   // tasks
   task automatic report_and_stop;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wrEn <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      rdEn <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rdEn <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   function automatic logic sel(input int s);
      case (s)
         0: return rxFullIrq;
         1: return xferReq;
         default: return rxErrIrq;
      endcase
   endfunction
   task automatic waitfor(input int s);
      for (int k = 0; k < 400 && sel(s) !== 1'b1; k++) @(posedge clk_sys);
      chk({7'h0, sel(s)}, 8'h01);
   endtask
   // counts pin toggles over 64 link cycles; 16 when running
   task automatic edges();
      logic p;
      n = 0;
      p = sckOut;
      repeat (64) begin
         @(posedge clkLink);
         #1 if (sckOut !== p) n++;
         p = sckOut;
      end
   endtask

   // ==========================
   // tests
   initial begin
      {arst_n, wrEn, rdEn, lowPower, xferDone, addr, wdata} = '0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(ADDR_CTRL, CTL_RESET);
      rd(ADDR_STAT, STA_RESET);
      rd(ADDR_PORT, PRT_RESET);
      peer_inst_send(8'h11);
      rd(ADDR_STAT, 8'h00);
      wr(ADDR_CTRL, 8'h90);
      peer_inst_send(8'ha5);
      waitfor(0);
      rd(ADDR_STAT, 8'h40);
      rd(ADDR_RXDATA, 8'ha5);
      wr(ADDR_STAT, 8'h00);
      rd(ADDR_STAT, 8'h00);
      wr(ADDR_PORT, 8'h80);
      peer_inst_send(8'h3c);
      waitfor(1);
      chk({7'h0, rxFullIrq}, 8'h00);
      @(posedge clk_sys);
      xferDone <= 1'b1;
      @(posedge clk_sys);
      xferDone <= 1'b0;
      rd(ADDR_STAT, 8'h00);
      rd(ADDR_RXDATA, 8'h3c);
      wr(ADDR_PORT, 8'h00);
      wr(ADDR_CTRL, 8'hd0);
      for (int i = 0; i < 2; i++) begin
         e = 8'h08 << i;
         scrx_peer_inst.send(8'h69, i == 0, i == 1);
         waitfor(2);
         rd(ADDR_STAT, e);
         wr(ADDR_STAT, 8'hff);
         rd(ADDR_STAT, e);
         wr(ADDR_STAT, 8'h00);
         rd(ADDR_STAT, 8'h00);
      end
      // receive left enabled so the word in flight must be discarded
      fork
         peer_inst_send(8'hc3);
         begin
            repeat (50) @(posedge clk_sys);
            lowPower <= 1'b1;
         end
      join
      repeat (3) @(posedge clk_sys);
      lowPower <= 1'b0;
      rd(ADDR_STAT, 8'h00);
      rd(ADDR_RXDATA, 8'h00);
      wr(ADDR_PORT, 8'h00);
      wr(ADDR_CTRL, 8'hd0);
      peer_inst_send(8'h5a);
      waitfor(0);
      rd(ADDR_RXDATA, 8'h5a);
      wr(ADDR_PORT, 8'h03);
      // parked high level must stand a full phase before the clock starts
      repeat (8) @(posedge clkLink);
      wr(ADDR_CTRL, 8'h01);
      repeat (8) @(posedge clkLink);
      edges();
      chk(8'(n), 8'd16);
      wr(ADDR_CTRL, 8'h03);
      wr(ADDR_CTRL, 8'h02);
      repeat (16) @(posedge clkLink);
      edges();
      chk(8'(n), 8'd0);
      chk({6'h0, sckOe, sckOut}, 8'h03);
      @(posedge clk_sys);
      lowPower <= 1'b1;
      repeat (10) @(posedge clk_sys);
      lowPower <= 1'b0;
      wr(ADDR_CTRL, 8'h01);
      repeat (8) @(posedge clkLink);
      edges();
      chk(8'(n), 8'd16);
      report_and_stop;
   end

   task automatic peer_inst_send(input logic [7:0] d);
      scrx_peer_inst.send(d, 1'b0, 1'b0);
   endtask
endmodule

`default_nettype wire
